// ==== crosspoint_serial_chain_control_tb.sv ====
// Purpose: self-checking bench for the chain control block
// Assumes: zero-wait apb slave, host model on the serial pins
// Notes: shutdown load, chain echo, parallel write, mid-run reset
`timescale 1ns/100ps
`default_nettype none
module crosspoint_serial_chain_control_tb;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, echo;
  logic serialClk, serialSelN, serialIn, commitStrobeN, powerDownInput, chainOut;
  logic [3:0] ampEnable;
  logic [15:0] ampCode;
  int errCount = 0;
  int samplesChecked = 0;
  xps_chain_ctrl u_xps_chain_ctrl (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialClk(serialClk), .serialSelN(serialSelN),
    .serialIn(serialIn), .commitStrobeN(commitStrobeN), .powerDownInput(powerDownInput),
    .chainOut(chainOut), .ampEnable(ampEnable), .ampCode(ampCode));
  xps_host_model u_xps_host_model (.serialClk(serialClk), .serialSelN(serialSelN),
    .serialIn(serialIn), .chainOut(chainOut), .echo(echo));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic commit();
    commitStrobeN <= 1'b0;
    repeat (10) @(posedge clock);
    commitStrobeN <= 1'b1;
    repeat (10) @(posedge clock);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset_state();
    check({28'h0, ampEnable}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check(r, 32'h8888);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, e}, 32'h1);
  endtask
  // shut down, load two words in one frame, then release
  task automatic t_shutdown_load();
    powerDownInput <= 1'b1;
    // top bit of the second word is ignored by the slots but ends up on the chain output
    u_xps_host_model.frame({16'h0015, 16'h8026}, 32);
    @(posedge clock);
    check({16'h0, ampCode}, 32'h8888);
    check(echo, 32'h0000_0015);
    check({31'h0, chainOut}, 32'h1);
    commit();
    check({16'h0, ampCode}, 32'h8658);
    check({28'h0, ampEnable}, 32'h0);
    powerDownInput <= 1'b0;
    repeat (10) @(posedge clock);
    check({28'h0, ampEnable}, 32'h6);
    apb(1'b0, 8'h04, 32'h0);
    check({16'h0, r[31:16]}, 32'h2);
  endtask
  // single device: no output here is wired in parallel with another
  task automatic t_parallel();
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h33);
    apb(1'b1, 8'h0c, 32'h18);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    check(r, 32'h8658);
    commit();
    apb(1'b0, 8'h08, 32'h0);
    check(r, 32'h3688);
    check({28'h0, ampEnable}, 32'hc);
  endtask
  // a cut 8-bit frame is dropped; the next full block starts clean
  task automatic t_partial();
    u_xps_host_model.frame(32'h0000_003f, 8);
    repeat (10) @(posedge clock);
    u_xps_host_model.frame(32'h0000_0031, 16);
    repeat (2) @(posedge clock);
    apb(1'b0, 8'h0c, 32'h0);
    check(r, 32'h0000_0031);
    apb(1'b0, 8'h04, 32'h0);
    check({16'h0, r[31:16]}, 32'h3);
  endtask
  task automatic t_mid_reset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    check({16'h0, ampCode}, 32'h8888);
    check({28'h0, ampEnable}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(r, xps_pkg::XPS_CTRL_RESET);
  endtask
  initial
  begin
    // nba so the async reset branch sees an edge before the first clock
    sys_rst <= 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    commitStrobeN = 1'b1;
    powerDownInput = 1'b0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    t_reset_state();
    t_shutdown_load();
    t_parallel();
    t_partial();
    t_mid_reset();
    finish_test();
  end
  initial
  begin
    #200000;
    errCount++;
    finish_test();
  end
endmodule
`default_nettype wire

// ==== xps_chain_ctrl.sv ====
// Purpose: serial chain receiver, input/switch register banks, output enables
// Assumes: serial pins are asynchronous and sampled by the 200 MHz clock
// Notes: serial clock must be slow enough to be oversampled (64 ns bench period)
// Overview of operation
// - all amplifiers sit in high impedance after power-up unless programmed
// - a disabled amplifier drops its output enable so lines can be shared
// - input registers keep accepting writes while shutdown is asserted
// - power-down input low with the control power-down bit clear leaves shutdown and programmed selection drives outputs
// - reset starts every amplifier disabled whatever the power-down input
// - chain output repeats serial input sixteen serial clocks later
// - chain output changes only on serial clock falling edges with select low
// - with select high chain output holds the last bit shifted out
// - chain output is always driven, never high impedance
// - serial data is accepted in 16-bit blocks
// - switch registers load from input registers on commit strobe falling edge
// - disable bit disables the addressed amplifier and floats its output
`timescale 1ns/100ps
`default_nettype none
module xps_chain_ctrl
  import xps_pkg::*;
#(
  parameter int WORD_BITS = XPS_WORD_BITS
)
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic serialClk, // serial clock pin
  input wire logic serialSelN, // serial select pin, active low
  input wire logic serialIn, // serial data pin
  input wire logic commitStrobeN, // switch commit strobe, active low
  input wire logic powerDownInput, // shutdown pin, active high
  output logic chainOut, // chain serial output
  output logic [3:0] ampEnable, // amplifier output enables
  output logic [15:0] ampCode // per amp: dis bit and 3-bit input
);
  import xps_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [XPS_SYNC_STAGES-1:0] syncClk, syncSel, syncDin, syncCom, syncPd;
  logic [XPS_SYNC_STAGES-1:0] next_syncClk, next_syncSel, next_syncDin, next_syncCom;
  logic [XPS_SYNC_STAGES-1:0] next_syncPd;
  logic sclkS, sclkPrev, selS, comS, comPrev, pdS, dinS;
  logic next_sclkS, next_sclkPrev, next_selS, next_comS, next_comPrev, next_pdS;

  // a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic held);
    filt = (s[1] == s[2]) ? s[2] : held;
  endfunction

  always_comb
  begin
    next_syncClk = {syncClk[1:0], serialClk};
    next_syncSel = {syncSel[1:0], serialSelN};
    next_syncDin = {syncDin[1:0], serialIn};
    next_syncCom = {syncCom[1:0], commitStrobeN};
    next_syncPd = {syncPd[1:0], powerDownInput};
    next_sclkS = filt(syncClk, sclkS);
    next_sclkPrev = sclkS;
    next_selS = filt(syncSel, selS);
    next_comS = filt(syncCom, comS);
    next_comPrev = comS;
    next_pdS = filt(syncPd, pdS);
  end
  assign dinS = syncDin[2];

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncClk <= '0;
      syncSel <= '1;
      syncDin <= '0;
      syncCom <= '1;
      syncPd <= '0;
      sclkS <= 1'b0;
      sclkPrev <= 1'b0;
      selS <= 1'b1;
      comS <= 1'b1;
      comPrev <= 1'b1;
      pdS <= 1'b0;
    end
    else
    begin
      syncClk <= next_syncClk;
      syncSel <= next_syncSel;
      syncDin <= next_syncDin;
      syncCom <= next_syncCom;
      syncPd <= next_syncPd;
      sclkS <= next_sclkS;
      sclkPrev <= next_sclkPrev;
      selS <= next_selS;
      comS <= next_comS;
      comPrev <= next_comPrev;
      pdS <= next_pdS;
    end
  end

  // ----------------------------------------
  // serial shifter, chain output, register banks
  // ----------------------------------------
  logic [31:0] ctrlReg, next_ctrlReg;
  logic [WORD_BITS-1:0] shiftReg, next_shiftReg;
  logic [4:0] bitCount, next_bitCount;
  logic chainBit, next_chainBit;
  logic [3:0] inputSlot [XPS_NUM_AMPS];
  logic [3:0] next_inputSlot [XPS_NUM_AMPS];
  logic [3:0] switchSlot [XPS_NUM_AMPS];
  logic [3:0] next_switchSlot [XPS_NUM_AMPS];
  logic [WORD_BITS-1:0] lastWord, next_lastWord;
  logic [15:0] wordCount, next_wordCount;
  logic serialMode, riseEdge, fallEdge, commitFall, wrActive;
  logic [1:0] wrAmp;

  // serial mode only with write strobe, chip enable and commit strobe idle
  assign serialMode = ctrlReg[XPS_CTRL_WR_N] & ctrlReg[XPS_CTRL_CE_N] & comS & ~selS;
  assign riseEdge = sclkS & ~sclkPrev;
  assign fallEdge = ~sclkS & sclkPrev;
  assign commitFall = comPrev & ~comS;
  assign wrActive = psel & penable & pwrite;
  assign wrAmp = pwdata[XPS_FLD_AMP_LSB +: 2];

  always_comb
  begin
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    next_chainBit = chainBit;
    next_lastWord = lastWord;
    next_wordCount = wordCount;
    next_inputSlot = inputSlot;
    next_switchSlot = switchSlot;
    next_ctrlReg = ctrlReg;
    if (serialMode && riseEdge)
    begin
      next_shiftReg = {shiftReg[WORD_BITS-2:0], dinS};
      next_bitCount = (bitCount == 5'(WORD_BITS - 1)) ? 5'd0 : bitCount + 5'd1;
      if (bitCount == 5'(WORD_BITS - 1))
      begin
        // a full block lands in the addressed input register, even in shutdown
        next_lastWord = {shiftReg[WORD_BITS-2:0], dinS};
        next_inputSlot[next_lastWord[XPS_FLD_AMP_LSB +: 2]] =
          next_lastWord[XPS_FLD_CODE_LSB +: 4];
        next_wordCount = wordCount + 16'd1;
      end
    end
    if (selS)
      next_bitCount = 5'd0;
    // msb of the shifter leaves on the falling edge: 16 clocks later
    if (serialMode && fallEdge)
      next_chainBit = shiftReg[WORD_BITS-1];
    if (wrActive && paddr == XPS_OFF_CTRL)
      next_ctrlReg = {29'd0, pwdata[2:0]};
    if (wrActive && paddr == XPS_OFF_WORD && !ctrlReg[XPS_CTRL_WR_N] && !ctrlReg[XPS_CTRL_CE_N])
      next_inputSlot[wrAmp] = pwdata[XPS_FLD_CODE_LSB +: 4];
    if (commitFall)
      next_switchSlot = next_inputSlot;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shiftReg <= '0;
      bitCount <= 5'd0;
      chainBit <= 1'b0;
      lastWord <= '0;
      wordCount <= 16'd0;
      ctrlReg <= XPS_CTRL_RESET;
      for (int i = 0; i < XPS_NUM_AMPS; i++)
      begin
        inputSlot[i] <= XPS_SLOT_RESET;
        switchSlot[i] <= XPS_SLOT_RESET;
      end
    end
    else
    begin
      shiftReg <= next_shiftReg;
      bitCount <= next_bitCount;
      chainBit <= next_chainBit;
      lastWord <= next_lastWord;
      wordCount <= next_wordCount;
      ctrlReg <= next_ctrlReg;
      inputSlot <= next_inputSlot;
      switchSlot <= next_switchSlot;
    end
  end

  assign chainOut = chainBit;

  // ----------------------------------------
  // amplifier outputs
  // ----------------------------------------
  logic shutdown;
  assign shutdown = pdS | ctrlReg[XPS_CTRL_PWRDN];

  genvar g;
  generate
    for (g = 0; g < XPS_NUM_AMPS; g++)
    begin : gAmp
      // disabled or shut down amps release their line
      assign ampEnable[g] = ~switchSlot[g][XPS_FLD_DIS] & ~shutdown;
      assign ampCode[4*g +: 4] = switchSlot[g];
    end
  endgenerate

  // ----------------------------------------
  // apb slave: zero wait states
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > XPS_OFF_WORD || paddr[1:0] != 2'b00);

  always_comb
  begin
    case (paddr)
      XPS_OFF_CTRL: prdata = ctrlReg;
      XPS_OFF_STATUS: prdata = {wordCount, 5'd0, shutdown, selS, chainBit, 4'd0, ampEnable};
      XPS_OFF_SEL: prdata = {16'd0, switchSlot[3], switchSlot[2], switchSlot[1], switchSlot[0]};
      XPS_OFF_WORD: prdata = {16'd0, lastWord};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// ==== xps_chain_ctrl_sva.sv ====
// Purpose: port checker for the chain control block
// Assumes: pins pass a 3-flop sync, about 4 clocks
// Notes: bound to the design module
`timescale 1ns/100ps
`default_nettype none
module xps_chain_ctrl_sva (
  input wire logic clock, // clock
  input wire logic sys_rst, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic pslverr, // apb
  input wire logic serialClk, // pin
  input wire logic serialSelN, // pin
  input wire logic commitStrobeN, // pin
  input wire logic powerDownInput, // pin
  input wire logic chainOut, // out
  input wire logic [3:0] ampEnable, // out
  input wire logic [15:0] ampCode // out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_shutdown_quiet: assert property (powerDownInput [*6] |-> ampEnable == 4'h0)
    else $error("amp driving in shutdown");
  a_dis_float: assert property ((ampEnable & {ampCode[15], ampCode[11], ampCode[7], ampCode[3]}) == 4'h0)
    else $error("disabled amp driving");
  a_sel_hold: assert property (serialSelN [*6] |=> $stable(chainOut))
    else $error("chain output moved with select high");
  a_fall_only: assert property ($changed(chainOut) |-> !$past(serialClk, 2) && !$past(serialSelN, 2))
    else $error("chain output moved off a falling edge");
  a_rst_init: assert property ($fell(sys_rst) |-> ampCode == 16'h8888 && ampEnable == 4'h0)
    else $error("slots not disabled after reset");
  a_commit_only: assert property ($changed(ampCode) |-> !$past(commitStrobeN, 2))
    else $error("switch slots changed without commit");
  a_rst_off: assert property (disable iff (1'b0) sys_rst |-> ampEnable == 4'h0)
    else $error("amp driving in reset");
  a_bad_addr: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
    else $error("unmapped access not flagged");
endmodule
bind xps_chain_ctrl xps_chain_ctrl_sva u_xps_chain_ctrl_sva (.clock(clock), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .serialClk(serialClk),
  .serialSelN(serialSelN), .commitStrobeN(commitStrobeN), .powerDownInput(powerDownInput),
  .chainOut(chainOut), .ampEnable(ampEnable), .ampCode(ampCode));
`default_nettype wire

// ==== xps_host_model.sv ====
// Purpose: host serial controller driving the serial pins
// Assumes: 64 ns serial clock, mode with clock idling low
// Notes: clock stands still outside frames
`timescale 1ns/100ps
`default_nettype none
module xps_host_model (
  output logic serialClk, // serial clock
  output logic serialSelN, // select, active low
  output logic serialIn, // data
  input wire logic chainOut, // chained output
  output logic [31:0] echo // chainOut seen at each rise
);
  initial
  begin
    serialClk = 1'b0;
    serialSelN = 1'b1;
    serialIn = 1'b0;
    echo = 32'h0;
  end
  // select held low for the whole frame, msb first
  task automatic frame(input logic [31:0] d, input int n);
    #1.3 serialSelN = 1'b0;
    #64;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn = d[i];
      #32 echo = {echo[30:0], chainOut};
      serialClk = 1'b1;
      #32 serialClk = 1'b0;
    end
    #32 serialSelN = 1'b1;
    // released data line must not look like a held bit
    serialIn = ~serialIn;
  endtask
endmodule
`default_nettype wire

// ==== xps_pkg.sv ====
// Purpose: shared constants for the crosspoint serial chain control block
// Assumes: 200 MHz system clock, APB register access
// Notes: offsets are byte addresses of aligned 32-bit words
package xps_pkg;
  localparam int XPS_WORD_BITS = 16;
  localparam int XPS_NUM_AMPS = 4;
  localparam logic [7:0] XPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] XPS_OFF_STATUS = 8'h04;
  localparam logic [7:0] XPS_OFF_SEL = 8'h08;
  localparam logic [7:0] XPS_OFF_WORD = 8'h0c;
  // word field layout: input code low nibble, amp select above it
  localparam int XPS_FLD_CODE_LSB = 0;
  localparam int XPS_FLD_DIS = 3;
  localparam int XPS_FLD_AMP_LSB = 4;
  // control register bit positions
  localparam int XPS_CTRL_WR_N = 0;
  localparam int XPS_CTRL_CE_N = 1;
  localparam int XPS_CTRL_PWRDN = 2;
  localparam logic [31:0] XPS_CTRL_RESET = 32'h0000_0003;
  // all amplifiers disabled after reset: disable bit set in each slot
  localparam logic [3:0] XPS_SLOT_RESET = 4'h8;
  localparam int XPS_SYNC_STAGES = 3;
endpackage
